// file: hdl/phyan_regs_pkg.sv
package phyan_regs_pkg;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;

    // Address is {bank, offset}: the bank selects a group, the offset a register in it.
    localparam logic [5:0] BANK_P2_MII = 6'h2E;
    localparam logic [5:0] BANK_PHY_SPECIAL = 6'h2F;
    localparam logic [5:0] BANK_P1_ALIAS = 6'h31;
    localparam logic [5:0] BANK_P2_ALIAS = 6'h33;

    localparam logic [7:0] OFS_P2_ADVERTISE = 8'h08;
    localparam logic [7:0] OFS_P2_PARTNER = 8'h0A;
    localparam logic [7:0] OFS_P1_SPECIAL = 8'h02;
    localparam logic [7:0] OFS_P1_ALIAS_CTRL = 8'h00;
    localparam logic [7:0] OFS_P1_ALIAS_STAT = 8'h04;
    localparam logic [7:0] OFS_P2_ALIAS_CTRL = 8'h02;
    localparam logic [7:0] OFS_P2_ALIAS_STAT = 8'h04;

    // Ability field positions in the advertisement and partner words.
    localparam int POS_PAUSE = 10;
    localparam int POS_RSVD_ADV = 9;
    localparam int POS_F100 = 8;
    localparam int POS_H100 = 7;
    localparam int POS_F10 = 6;
    localparam int POS_H10 = 5;
    localparam logic [4:0] SELECTOR_8023 = 5'h01;

    // Ability positions in the port 2 alias view.
    localparam int ALS_PAUSE = 4;
    localparam int ALS_F100 = 3;
    localparam int ALS_H100 = 2;
    localparam int ALS_F10 = 1;
    localparam int ALS_H10 = 0;

    // Port 1 special register positions.
    localparam int POS_POL_REV = 5;
    localparam int POS_XOVER = 4;
    localparam int POS_FORCE_LINK = 3;
    localparam int POS_PWR_SAVE_DIS = 2;
    localparam int POS_REM_LOOP = 1;
    localparam int POS_RSVD_SPC = 0;

    // Port 1 alias view positions.
    localparam int ALS_POL_REV = 13;
    localparam int ALS_XOVER = 7;
    localparam int ALS_FORCE_LINK = 11;
    localparam int ALS_PWR_SAVE_DIS = 10;
    localparam int ALS_REM_LOOP = 9;

    typedef struct packed {
        logic pause;
        logic f100;
        logic h100;
        logic f10;
        logic h10;
    } phyan_ability_t;

    typedef struct packed {
        logic force_link;
        logic pwr_save_dis;
        logic rem_loop;
    } phyan_p1_ctrl_t;

    typedef struct packed {
        logic pol_rev;
        logic crossover_state_flag;
    } phyan_p1_stat_t;

    localparam phyan_ability_t ADV_RESET = '{pause: 1'b1, f100: 1'b1, h100: 1'b1, f10: 1'b1, h10: 1'b1};
    localparam phyan_p1_ctrl_t P1_CTRL_RESET = '{force_link: 1'b0, pwr_save_dis: 1'b1, rem_loop: 1'b0};
    localparam logic RSVD_RW_RESET = 1'b0;

    // Places the five ability bits and the selector into a 16-bit MII view.
    function automatic logic [DATA_W-1:0] phyan_mii_word(input phyan_ability_t ab, input logic rsvd);
        logic [DATA_W-1:0] w;
        w = 16'h0000;
        w[4:0] = SELECTOR_8023;
        w[POS_PAUSE] = ab.pause;
        w[POS_RSVD_ADV] = rsvd;
        w[POS_F100] = ab.f100;
        w[POS_H100] = ab.h100;
        w[POS_F10] = ab.f10;
        w[POS_H10] = ab.h10;
        return w;
    endfunction : phyan_mii_word

    // Places the five ability bits at the low end of the alias view.
    function automatic logic [DATA_W-1:0] phyan_alias_word(input phyan_ability_t ab);
        logic [DATA_W-1:0] w;
        w = 16'h0000;
        w[ALS_PAUSE] = ab.pause;
        w[ALS_F100] = ab.f100;
        w[ALS_H100] = ab.h100;
        w[ALS_F10] = ab.f10;
        w[ALS_H10] = ab.h10;
        return w;
    endfunction : phyan_alias_word

endpackage : phyan_regs_pkg

// file: hdl/phyan_regs.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// - Advertise pause bit 10, RW, reset 1
// - Advertise 100 full bit 8, RW, reset 1
// - Advertise 100 half bit 7, RW, reset 1
// - Advertise 10 full bit 6, RW, reset 1
// - Advertise 10 half bit 5, RW, reset 1
// - Advertise low bits read 0x01; NP/RF zero
// - Partner pause in bit 10, read-only
// - Partner 100 full in bit 8, read-only
// - Partner 100 half in bit 7, read-only
// - Partner 10 full in bit 6, read-only
// - Partner 10 half in bit 5, read-only
// - Partner bits 15..13 zero, low bits 0x01
// - Port 1 bit 5 shows reversed polarity
// - Port 1 bit 4: 1 MDI, 0 MDI-X
// - Port 1 bit 3 forces link pass
// - Port 1 bit 2 disables power saving
// - Port 1 bit 1 enables remote loopback
module phyan_regs
    import phyan_regs_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    input wire phyan_ability_t partner_ability_in,
    input wire phyan_p1_stat_t port1_status_in,
    output phyan_ability_t port2_advertise_out,
    output phyan_p1_ctrl_t port1_ctrl_out
);

    // Partner and status bits come from PHY logic outside this clock, so each bit is synchronised.
    phyan_ability_t partner_meta_r;
    phyan_ability_t partner_sync_r;
    phyan_p1_stat_t status_meta_r;
    phyan_p1_stat_t status_sync_r;

    phyan_ability_t adv_r;
    phyan_ability_t adv_nxt;
    logic adv_rsvd_r;
    logic adv_rsvd_nxt;
    phyan_p1_ctrl_t p1_ctrl_r;
    phyan_p1_ctrl_t p1_ctrl_nxt;
    logic p1_rsvd_r;
    logic p1_rsvd_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    wire logic [5:0] bank = addr_in[ADDR_W-1:8];
    wire logic [7:0] ofs = addr_in[7:0];

    // Every decode compares the whole address, so at most one hit is ever high.
    function automatic logic phyan_reg_hit(input logic [5:0] bk, input logic [7:0] of, input logic [5:0] want_bk,
            input logic [7:0] want_of);
        return (bk == want_bk) && (of == want_of);
    endfunction : phyan_reg_hit

    wire logic hit_adv = phyan_reg_hit(bank, ofs, BANK_P2_MII, OFS_P2_ADVERTISE);
    wire logic hit_partner = phyan_reg_hit(bank, ofs, BANK_P2_MII, OFS_P2_PARTNER);
    wire logic hit_p1_spc = phyan_reg_hit(bank, ofs, BANK_PHY_SPECIAL, OFS_P1_SPECIAL);
    wire logic hit_p2_als_ctrl = phyan_reg_hit(bank, ofs, BANK_P2_ALIAS, OFS_P2_ALIAS_CTRL);
    wire logic hit_p2_als_stat = phyan_reg_hit(bank, ofs, BANK_P2_ALIAS, OFS_P2_ALIAS_STAT);
    wire logic hit_p1_als_ctrl = phyan_reg_hit(bank, ofs, BANK_P1_ALIAS, OFS_P1_ALIAS_CTRL);
    wire logic hit_p1_als_stat = phyan_reg_hit(bank, ofs, BANK_P1_ALIAS, OFS_P1_ALIAS_STAT);

    // Both views of the advertisement land in the same flip-flops.
    wire logic wr_adv = wr_in && hit_adv;
    wire logic wr_adv_als = wr_in && hit_p2_als_ctrl;
    wire logic wr_p1 = wr_in && hit_p1_spc;
    wire logic wr_p1_als = wr_in && hit_p1_als_ctrl;

    // Advertisement write data, taken from whichever view was addressed.
    wire phyan_ability_t adv_from_mii = '{
        pause: wdata_in[POS_PAUSE],
        f100: wdata_in[POS_F100],
        h100: wdata_in[POS_H100],
        f10: wdata_in[POS_F10],
        h10: wdata_in[POS_H10]
    };
    wire phyan_ability_t adv_from_als = '{
        pause: wdata_in[ALS_PAUSE],
        f100: wdata_in[ALS_F100],
        h100: wdata_in[ALS_H100],
        f10: wdata_in[ALS_F10],
        h10: wdata_in[ALS_H10]
    };

    wire phyan_p1_ctrl_t p1_from_spc = '{
        force_link: wdata_in[POS_FORCE_LINK],
        pwr_save_dis: wdata_in[POS_PWR_SAVE_DIS],
        rem_loop: wdata_in[POS_REM_LOOP]
    };
    wire phyan_p1_ctrl_t p1_from_als = '{
        force_link: wdata_in[ALS_FORCE_LINK],
        pwr_save_dis: wdata_in[ALS_PWR_SAVE_DIS],
        rem_loop: wdata_in[ALS_REM_LOOP]
    };

    // Read-only bits are never in any write path, so they keep their fixed values.
    assign adv_nxt = wr_adv ? adv_from_mii : (wr_adv_als ? adv_from_als : adv_r);
    assign adv_rsvd_nxt = wr_adv ? wdata_in[POS_RSVD_ADV] : adv_rsvd_r;
    assign p1_ctrl_nxt = wr_p1 ? p1_from_spc : (wr_p1_als ? p1_from_als : p1_ctrl_r);
    assign p1_rsvd_nxt = wr_p1 ? wdata_in[POS_RSVD_SPC] : p1_rsvd_r;

    // Read views of each register.
    wire logic [DATA_W-1:0] adv_word = phyan_mii_word(adv_r, adv_rsvd_r);
    wire logic [DATA_W-1:0] partner_word = phyan_mii_word(partner_sync_r, 1'b0);
    wire logic [DATA_W-1:0] adv_als_word = phyan_alias_word(adv_r);
    wire logic [DATA_W-1:0] partner_als_word = phyan_alias_word(partner_sync_r);

    logic [DATA_W-1:0] p1_spc_word;
    logic [DATA_W-1:0] p1_als_ctrl_word;
    logic [DATA_W-1:0] p1_als_stat_word;

    always_comb begin
        p1_spc_word = 16'h0000;
        p1_spc_word[POS_POL_REV] = status_sync_r.pol_rev;
        p1_spc_word[POS_XOVER] = status_sync_r.crossover_state_flag;
        p1_spc_word[POS_FORCE_LINK] = p1_ctrl_r.force_link;
        p1_spc_word[POS_PWR_SAVE_DIS] = p1_ctrl_r.pwr_save_dis;
        p1_spc_word[POS_REM_LOOP] = p1_ctrl_r.rem_loop;
        p1_spc_word[POS_RSVD_SPC] = p1_rsvd_r;
    end

    always_comb begin
        p1_als_ctrl_word = 16'h0000;
        p1_als_ctrl_word[ALS_FORCE_LINK] = p1_ctrl_r.force_link;
        p1_als_ctrl_word[ALS_PWR_SAVE_DIS] = p1_ctrl_r.pwr_save_dis;
        p1_als_ctrl_word[ALS_REM_LOOP] = p1_ctrl_r.rem_loop;
    end

    always_comb begin
        p1_als_stat_word = 16'h0000;
        p1_als_stat_word[ALS_POL_REV] = status_sync_r.pol_rev;
        p1_als_stat_word[ALS_XOVER] = status_sync_r.crossover_state_flag;
    end

    // Unmapped addresses read as zero.
    assign rdata_nxt = !rd_in ? 16'h0000 :
        hit_adv ? adv_word :
        hit_partner ? partner_word :
        hit_p1_spc ? p1_spc_word :
        hit_p2_als_ctrl ? adv_als_word :
        hit_p2_als_stat ? partner_als_word :
        hit_p1_als_ctrl ? p1_als_ctrl_word :
        hit_p1_als_stat ? p1_als_stat_word : 16'h0000;

    // Only the second stage is read; the first may be metastable for a cycle.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            partner_meta_r <= '0;
            partner_sync_r <= '0;
        end else begin
            partner_meta_r <= partner_ability_in;
            partner_sync_r <= partner_meta_r;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            status_meta_r <= '0;
            status_sync_r <= '0;
        end else begin
            status_meta_r <= port1_status_in;
            status_sync_r <= status_meta_r;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            adv_r <= ADV_RESET;
        end else begin
            adv_r <= adv_nxt;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            adv_rsvd_r <= RSVD_RW_RESET;
        end else begin
            adv_rsvd_r <= adv_rsvd_nxt;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            p1_ctrl_r <= P1_CTRL_RESET;
        end else begin
            p1_ctrl_r <= p1_ctrl_nxt;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            p1_rsvd_r <= RSVD_RW_RESET;
        end else begin
            p1_rsvd_r <= p1_rsvd_nxt;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Read data stands for exactly one cycle after the read strobe, zero otherwise.
    assign rdata_out = rdata_r;
    assign port2_advertise_out = adv_r;
    assign port1_ctrl_out = p1_ctrl_r;

endmodule : phyan_regs

// file: test/phyan_phy_model.sv
`timescale 1ns/1ps
// The PHY side changes its status on the falling edge, so the block must resynchronise it.
module phyan_phy_model
    import phyan_regs_pkg::*;
(
    input wire logic core_clk_in,
    input wire phyan_ability_t ab_cmd_in,
    input wire phyan_p1_stat_t st_cmd_in,
    output phyan_ability_t partner_ability_out,
    output phyan_p1_stat_t port1_status_out
);
    initial partner_ability_out = '0;
    initial port1_status_out = '0;
    always @(negedge core_clk_in) begin
        partner_ability_out <= ab_cmd_in;
        port1_status_out <= st_cmd_in;
    end
endmodule : phyan_phy_model

// file: test/phyan_regs_sva.sv
`timescale 1ns/1ps
module phyan_regs_sva
    import phyan_regs_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire phyan_ability_t partner_ability_in,
    input wire phyan_p1_stat_t port1_status_in,
    input wire phyan_ability_t port2_advertise_out,
    input wire phyan_p1_ctrl_t port1_ctrl_out
);
    localparam logic [13:0] A_ADV = {BANK_P2_MII, OFS_P2_ADVERTISE};
    localparam logic [13:0] A_LP = {BANK_P2_MII, OFS_P2_PARTNER};
    localparam logic [13:0] A_SPC = {BANK_PHY_SPECIAL, OFS_P1_SPECIAL};
    localparam logic [13:0] A_AADV = {BANK_P2_ALIAS, OFS_P2_ALIAS_CTRL};
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    rdata_idle_a: assert property (!rd_in |=> rdata_out == '0)
        else $error("read data not zero outside a read");
    adv_fixed_a: assert property (rd_in && addr_in == A_ADV |=>
        rdata_out[15:11] == '0 && rdata_out[4:0] == SELECTOR_8023) else $error("advertise fixed bits wrong");
    lp_fixed_a: assert property (rd_in && addr_in == A_LP |=>
        {rdata_out[15:11], rdata_out[9]} == '0 && rdata_out[4:0] == SELECTOR_8023) else $error("partner fixed bits wrong");
    adv_read_a: assert property (rd_in && addr_in == A_ADV |=>
        {rdata_out[10], rdata_out[8:5]} == $past(port2_advertise_out)) else $error("advertise read mismatch");
    adv_write_a: assert property (wr_in && addr_in == A_ADV |=>
        port2_advertise_out == $past({wdata_in[10], wdata_in[8:5]})) else $error("advertise write lost");
    alias_write_a: assert property (wr_in && addr_in == A_AADV |=>
        port2_advertise_out == $past(wdata_in[4:0])) else $error("alias write lost");
    spc_write_a: assert property (wr_in && addr_in == A_SPC |=>
        port1_ctrl_out == $past(wdata_in[3:1])) else $error("special write lost");
    spc_read_a: assert property (rd_in && addr_in == A_SPC |=>
        rdata_out[15:6] == '0 && rdata_out[3:1] == $past(port1_ctrl_out)) else $error("special read mismatch");
    ctrl_hold_a: assert property (!wr_in |=> $stable({port2_advertise_out, port1_ctrl_out}))
        else $error("control changed without write");
    cover property (wr_in && addr_in == A_ADV);
    cover property (rd_in && addr_in == A_LP);
    cover property (wr_in && addr_in == A_AADV);
endmodule : phyan_regs_sva
bind phyan_regs phyan_regs_sva u_sva (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .partner_ability_in(partner_ability_in), .port1_status_in(port1_status_in),
    .port2_advertise_out(port2_advertise_out), .port1_ctrl_out(port1_ctrl_out));

// file: test/phyan_regs_bench.sv
`timescale 1ns/1ps
module phyan_regs_bench;
    import phyan_regs_pkg::*;
    localparam logic [13:0] A_ADV = {BANK_P2_MII, OFS_P2_ADVERTISE};
    localparam logic [13:0] A_LP = {BANK_P2_MII, OFS_P2_PARTNER};
    localparam logic [13:0] A_SPC = {BANK_PHY_SPECIAL, OFS_P1_SPECIAL};
    localparam logic [13:0] A_AADV = {BANK_P2_ALIAS, OFS_P2_ALIAS_CTRL};
    localparam logic [13:0] A_ALP = {BANK_P2_ALIAS, OFS_P2_ALIAS_STAT};
    localparam logic [13:0] A_ACT = {BANK_P1_ALIAS, OFS_P1_ALIAS_CTRL};
    localparam logic [13:0] A_AST = {BANK_P1_ALIAS, OFS_P1_ALIAS_STAT};
    logic core_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wdata_in = '0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic rd_d = 1'b0;
    logic r9, r0;
    logic [DATA_W-1:0] rdata_out, d;
    logic [DATA_W-1:0] exp_q[$];
    phyan_ability_t partner_ability_in, port2_advertise_out, ab_cmd = '0;
    phyan_p1_stat_t port1_status_in, st_cmd = '0;
    phyan_p1_ctrl_t port1_ctrl_out;
    int num_errors = 0;
    int comparisons = 0;
    initial forever #50 core_clk_in = ~core_clk_in;
    phyan_regs uut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .partner_ability_in(partner_ability_in),
        .port1_status_in(port1_status_in), .port2_advertise_out(port2_advertise_out),
        .port1_ctrl_out(port1_ctrl_out));
    phyan_phy_model phy (.core_clk_in(core_clk_in), .ab_cmd_in(ab_cmd), .st_cmd_in(st_cmd),
        .partner_ability_out(partner_ability_in), .port1_status_out(port1_status_in));
    task automatic test_done();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic r, input logic [13:0] a, input logic [15:0] dv);
        @(posedge core_clk_in);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= dv;
        if (r) exp_q.push_back(dv);
    endtask : bus
    // The read task carries its expectation on the data lines; the block ignores them during a read.
    always @(posedge core_clk_in) rd_d <= rd_in;
    always @(negedge core_clk_in) begin
        if (rd_d === 1'b1) chk("rdata_out", rdata_out, exp_q.pop_front());
    end
    initial begin
        #300us;
        num_errors++;
        test_done();
    end
    initial begin
        void'($urandom(32'hA79D));
        repeat (2) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            chk("advertise", {11'h000, port2_advertise_out}, 16'h001F);
            chk("ctrl", {13'h0000, port1_ctrl_out}, 16'h0002);
            bus(0, 1, A_ADV, 16'h05E1);
            bus(0, 1, A_LP, 16'h0001);
            bus(0, 1, A_SPC, 16'h0004);
            bus(0, 1, A_ACT, 16'h0400);
            bus(1, 0, 14'h2E0C, 16'hFFFF);
            bus(0, 1, 14'h2E0C, 16'h0000);
            r0 = 1'b0;
            repeat (4) begin
                ab_cmd <= 5'($urandom);
                st_cmd <= 2'($urandom);
                d = 16'($urandom);
                bus(1, 0, A_ADV, d);
                bus(0, 1, A_ADV, (d & 16'h07E0) | 16'h0001);
                bus(0, 1, A_AADV, {11'h000, d[10], d[8:5]});
                r9 = d[9];
                d = 16'($urandom);
                bus(1, 0, A_AADV, d);
                bus(0, 1, A_ADV, {5'h00, d[4], r9, d[3:0], 5'h01});
                bus(1, 0, A_LP, 16'hFFFF);
                bus(0, 1, A_LP, {5'h00, ab_cmd.pause, 1'b0, ab_cmd[3:0], 5'h01});
                bus(0, 1, A_ALP, {11'h000, ab_cmd});
                bus(0, 1, A_AST, {2'h0, st_cmd.pol_rev, 5'h00, st_cmd.crossover_state_flag, 7'h00});
                d = 16'($urandom);
                bus(1, 0, A_SPC, d);
                bus(0, 1, A_SPC, {10'h000, st_cmd, d[3:0]});
                bus(0, 1, A_ACT, {4'h0, d[3:1], 9'h000});
                r0 = d[0];
                d = 16'($urandom);
                bus(1, 0, A_ACT, d);
                bus(0, 1, A_SPC, {10'h000, st_cmd, d[11:9], r0});
            end
            ab_cmd <= '0;
            st_cmd <= '0;
            repeat (5) bus(0, 0, '0, '0);
            arst_n_in <= 1'b0;
            repeat (2) bus(0, 0, '0, '0);
            arst_n_in <= 1'b1;
        end
        repeat (2) bus(0, 0, '0, '0);
        test_done();
    end
endmodule : phyan_regs_bench
